// ---- inc/chgport_pkg.sv ----
/*
 * Shared constants, codes and carriers for the charging-port control block.
 * Assumes a single 40 MHz clock and analog comparators that deliver plain levels.
 */
package chgport_pkg;

    // Timing
    localparam int unsigned CLK_KHZ          = 40_000;
    localparam int unsigned LD_ASSERT_MS     = 200;
    localparam int unsigned LD_RELEASE_MS    = 3000;
    localparam int unsigned PW_IDLE_MS       = 15000;
    localparam int unsigned PW_DISCH_MS      = 2000;
    localparam int unsigned DEGLITCH_MS      = 8;
    localparam int unsigned ATTACH_DISCH_MS  = 100;
    localparam int unsigned MODE_DISCH_MS    = 100;
    localparam int unsigned V12_HOLD_MS      = 20;
    localparam int unsigned DIVB_TEST_MS     = 500;
    localparam int unsigned LD_ASSERT_CYC    = CLK_KHZ * LD_ASSERT_MS;
    localparam int unsigned LD_RELEASE_CYC   = CLK_KHZ * LD_RELEASE_MS;
    localparam int unsigned PW_IDLE_CYC      = CLK_KHZ * PW_IDLE_MS + 1;
    localparam int unsigned PW_DISCH_CYC     = CLK_KHZ * PW_DISCH_MS + 1;
    localparam int unsigned DEGLITCH_CYC     = CLK_KHZ * DEGLITCH_MS;
    localparam int unsigned ATTACH_DISCH_CYC = CLK_KHZ * ATTACH_DISCH_MS;
    localparam int unsigned MODE_DISCH_CYC   = CLK_KHZ * MODE_DISCH_MS;
    localparam int unsigned V12_HOLD_CYC     = CLK_KHZ * V12_HOLD_MS;
    localparam int unsigned DIVB_TEST_CYC    = CLK_KHZ * DIVB_TEST_MS;

    // Mode pin codes {one, two, three, limit select}
    localparam logic [3:0] MODE_STANDARD_PORT_VARIANT_B   = 4'hE;
    localparam logic [3:0] MODE_CDP    = 4'hF;
    localparam logic [3:0] MODE_DCP_LD = 4'h7;
    localparam logic [3:0] MODE_PW     = 4'h3;
    // Groups by the three mode pins alone
    localparam logic [2:0] GRP_DISCH   = 3'h0;
    localparam logic [2:0] GRP_AUTO_A  = 3'h1;
    localparam logic [2:0] GRP_AUTO_B  = 3'h3;
    localparam logic [2:0] GRP_SHORT   = 3'h4;
    localparam logic [2:0] GRP_DIV     = 3'h5;
    localparam logic [2:0] GRP_STD     = 3'h7;

    typedef enum logic [4:0] {
        AUTO_DIV_A = 5'h01,
        AUTO_DIV_B = 5'h02,
        AUTO_DISCH = 5'h04,
        AUTO_V12   = 5'h08,
        AUTO_BC12  = 5'h10
    } auto_state_t;

    typedef enum logic [2:0] {
        PW_FULL  = 3'h1,
        PW_IDLE  = 3'h2,
        PW_DISCH = 3'h4
    } pw_state_t;

    typedef enum logic [1:0] {
        SCH_DIV_A = 2'h0,
        SCH_DIV_B = 2'h1,
        SCH_V12   = 2'h2,
        SCH_SHORT = 2'h3
    } scheme_t;

    typedef struct packed {
        logic mode_pin_one;
        logic mode_pin_two;
        logic mode_pin_three;
        logic limit_select_pin;
    } mode_pins_t;

    typedef struct packed {
        logic load_above_assert;
        logic load_below_release;
        logic primary_detect;
        logic device_attach;
        logic line_released;
        logic chg_above_750;
        logic chg_below_45;
        logic in_current_limit;
        logic over_135;
        logic over_155;
        logic cooled;
        logic vin_above_on;
        logic vin_below_off;
    } sense_t;

    typedef struct packed {
        logic    switch_on;
        logic    discharge;
        logic    high_limit_sel;
        logic    pw_limit;
        scheme_t scheme;
    } port_ctrl_t;

endpackage

// ---- core/bit_sync.sv ----
/*
 * Two-flop synchroniser for a bundle of independent levels.
 * Assumes each bit is a slow level; no relation between bits is kept.
 */
`timescale 1ns/1ps
module bit_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         arst_n,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // bit_sync

// ---- core/dwell_timer.sv ----
/*
 * Counts consecutive cycles of a condition; done rises after target cycles.
 * Assumes target is at least one; run low clears the count at once.
 */
`timescale 1ns/1ps
module dwell_timer (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // Condition and length
    input  wire logic        run,
    input  wire logic [31:0] target,
    output logic             done
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic        done_d;

    always_comb begin
        cnt_d  = cnt_q;
        done_d = done;
        if (!run) begin
            cnt_d  = '0;
            done_d = 1'b0;
        end else if (!done) begin
            if (cnt_q >= target - 32'h00000001) begin
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 32'h00000001;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
            done  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            done  <= done_d;
        end
    end
endmodule // dwell_timer

// ---- core/charge_port_ctrl.sv ----
/*
 * Charging-port control: load-present, fault, protection and scheme selection.
 * Assumes pins and comparator levels are asynchronous; the power stage obeys ctrl.
 */
`timescale 1ns/1ps
module charge_port_ctrl #(
    parameter int unsigned LD_ASSERT_CYC    = chgport_pkg::LD_ASSERT_CYC,
    parameter int unsigned LD_RELEASE_CYC   = chgport_pkg::LD_RELEASE_CYC,
    parameter int unsigned PW_IDLE_CYC      = chgport_pkg::PW_IDLE_CYC,
    parameter int unsigned PW_DISCH_CYC     = chgport_pkg::PW_DISCH_CYC,
    parameter int unsigned DEGLITCH_CYC     = chgport_pkg::DEGLITCH_CYC,
    parameter int unsigned ATTACH_DISCH_CYC = chgport_pkg::ATTACH_DISCH_CYC,
    parameter int unsigned MODE_DISCH_CYC   = chgport_pkg::MODE_DISCH_CYC,
    parameter int unsigned V12_HOLD_CYC     = chgport_pkg::V12_HOLD_CYC,
    parameter int unsigned DIVB_TEST_CYC    = chgport_pkg::DIVB_TEST_CYC
) (
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    arst_n,
    // Mode pins and analog sense levels
    input  wire chgport_pkg::mode_pins_t mode_pins,
    input  wire chgport_pkg::sense_t     sense,
    // Power stage control
    output chgport_pkg::port_ctrl_t      ctrl,
    // Open-drain load-present and fault pins
    output logic                         load_present_out,
    output logic                         load_present_oe,
    output logic                         fault_out,
    output logic                         fault_oe
);
    chgport_pkg::mode_pins_t  pins_s;
    chgport_pkg::sense_t      sense_s;
    chgport_pkg::auto_state_t auto_q, auto_d;
    chgport_pkg::pw_state_t   pw_q, pw_d;
    chgport_pkg::port_ctrl_t  ctrl_d;
    logic [3:0]  mode, prev_q;
    logic [31:0] disch_len_q, disch_len_d, sched_len;
    logic is_cdp, is_dcp_ld, is_pw, is_auto, is_short, is_div, is_disch_mode, ld_active;
    logic mode_chg, auto_start, pw_start;
    logic at_done, rt_done, pw_done, dg_done, ds_done, sc_done;
    logic ld_q, ld_d, disch_q, disch_d, therm_q, therm_d, uv_q, uv_d;
    logic lp_d, fault_d;

    bit_sync #(.W($bits(chgport_pkg::mode_pins_t))) u_sync_pins (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .d       (mode_pins),
        .q       (pins_s)
    );
    bit_sync #(.W($bits(chgport_pkg::sense_t))) u_sync_sense (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .d       (sense),
        .q       (sense_s)
    );

    // Mode decode
    assign mode          = pins_s;
    assign is_cdp        = (mode == chgport_pkg::MODE_CDP);
    assign is_dcp_ld     = (mode == chgport_pkg::MODE_DCP_LD);
    assign is_pw         = (mode == chgport_pkg::MODE_PW);
    assign is_auto       = (mode[3:1] == chgport_pkg::GRP_AUTO_A) || (mode[3:1] == chgport_pkg::GRP_AUTO_B);
    assign is_short      = (mode[3:1] == chgport_pkg::GRP_SHORT);
    assign is_div        = (mode[3:1] == chgport_pkg::GRP_DIV);
    assign is_disch_mode = (mode[3:1] == chgport_pkg::GRP_DISCH);
    assign ld_active     = is_cdp || is_dcp_ld;
    // Limit select alone never discharges, so variant B and downstream swap freely
    assign mode_chg      = (mode[3:1] != prev_q[3:1]);
    assign auto_start    = is_auto && (auto_q == chgport_pkg::AUTO_DIV_A) && sense_s.device_attach;
    assign pw_start      = is_pw && (pw_q == chgport_pkg::PW_IDLE) && sense_s.in_current_limit;
    assign sched_len     = (auto_q == chgport_pkg::AUTO_V12) ? V12_HOLD_CYC : DIVB_TEST_CYC;

    // Dwell timers
    dwell_timer u_t_assert (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .run     (ld_active && !ld_q && sense_s.load_above_assert),
        .target  (LD_ASSERT_CYC),
        .done    (at_done)
    );
    dwell_timer u_t_release (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .run     (ld_active && ld_q && sense_s.load_below_release),
        .target  (LD_RELEASE_CYC),
        .done    (rt_done)
    );
    dwell_timer u_t_pw_idle (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .run     (is_pw && (pw_q == chgport_pkg::PW_FULL) && sense_s.chg_below_45),
        .target  (PW_IDLE_CYC),
        .done    (pw_done)
    );
    dwell_timer u_t_deglitch (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .run     (sense_s.in_current_limit),
        .target  (DEGLITCH_CYC),
        .done    (dg_done)
    );
    dwell_timer u_t_discharge (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .run     (disch_q),
        .target  (disch_len_q),
        .done    (ds_done)
    );
    dwell_timer u_t_scheme (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .run     (is_auto && (auto_q == chgport_pkg::AUTO_DIV_B || auto_q == chgport_pkg::AUTO_V12)),
        .target  (sched_len),
        .done    (sc_done)
    );

    // Load-present for downstream and dedicated detect modes
    always_comb begin
        ld_d = ld_q;
        if (!ld_active) begin
            ld_d = 1'b0;
        end else if (is_cdp && sense_s.primary_detect) begin
            ld_d = 1'b1;
        end else if (at_done) begin
            ld_d = 1'b1;
        end else if (rt_done) begin
            ld_d = 1'b0;
        end
    end

    // Discharge requests; one at a time, requests arriving during a discharge are dropped
    always_comb begin
        disch_d     = disch_q;
        disch_len_d = disch_len_q;
        if (disch_q) begin
            if (ds_done) begin
                disch_d = 1'b0;
            end
        end else if (pw_start) begin
            disch_d     = 1'b1;
            disch_len_d = PW_DISCH_CYC;
        end else if (auto_start) begin
            disch_d     = 1'b1;
            disch_len_d = ATTACH_DISCH_CYC;
        end else if (mode_chg) begin
            disch_d     = 1'b1;
            disch_len_d = MODE_DISCH_CYC;
        end
    end

    // Dedicated auto scheme selection
    always_comb begin
        auto_d = auto_q;
        if (!is_auto) begin
            auto_d = chgport_pkg::AUTO_DIV_A;
        end else begin
            unique case (auto_q)
                chgport_pkg::AUTO_DIV_A: begin
                    if (sense_s.device_attach) begin
                        auto_d = chgport_pkg::AUTO_DISCH;
                    end else if (sense_s.chg_above_750) begin
                        auto_d = chgport_pkg::AUTO_DIV_B;
                    end
                end
                chgport_pkg::AUTO_DIV_B: begin
                    if (sc_done && !sense_s.chg_above_750) begin
                        auto_d = chgport_pkg::AUTO_DIV_A;
                    end
                end
                chgport_pkg::AUTO_DISCH: begin
                    if (!disch_q) begin
                        auto_d = chgport_pkg::AUTO_V12;
                    end
                end
                chgport_pkg::AUTO_V12: begin
                    if (sc_done) begin
                        auto_d = chgport_pkg::AUTO_BC12;
                    end
                end
                chgport_pkg::AUTO_BC12: begin
                    if (sense_s.line_released) begin
                        auto_d = chgport_pkg::AUTO_DIV_A;
                    end
                end
                default: auto_d = chgport_pkg::AUTO_DIV_A;
            endcase
        end
    end

    // Supply-wake load detect
    always_comb begin
        pw_d = pw_q;
        if (!is_pw) begin
            pw_d = chgport_pkg::PW_FULL;
        end else begin
            unique case (pw_q)
                chgport_pkg::PW_FULL:  if (pw_done) pw_d = chgport_pkg::PW_IDLE;
                chgport_pkg::PW_IDLE:  if (pw_start) pw_d = chgport_pkg::PW_DISCH;
                chgport_pkg::PW_DISCH: if (!disch_q) pw_d = chgport_pkg::PW_FULL;
                default:               pw_d = chgport_pkg::PW_FULL;
            endcase
        end
    end

    // Protection: thermal retry and undervoltage lock with two thresholds
    always_comb begin
        if (therm_q) begin
            therm_d = !sense_s.cooled;
        end else begin
            therm_d = (sense_s.over_135 && sense_s.in_current_limit) || sense_s.over_155;
        end
        if (uv_q) begin
            uv_d = !sense_s.vin_above_on;
        end else begin
            uv_d = sense_s.vin_below_off;
        end
    end

    // Output values
    always_comb begin
        ctrl_d.switch_on      = !uv_q && !therm_q && !disch_q && !is_disch_mode;
        ctrl_d.discharge      = disch_q || is_disch_mode;
        ctrl_d.high_limit_sel = (is_cdp || is_auto) ? 1'b1 : mode[0];
        ctrl_d.pw_limit       = is_pw && (pw_q == chgport_pkg::PW_IDLE);
        if (is_short) begin
            ctrl_d.scheme = chgport_pkg::SCH_SHORT;
        end else if (is_div || !is_auto) begin
            ctrl_d.scheme = chgport_pkg::SCH_DIV_A;
        end else if (auto_q == chgport_pkg::AUTO_DIV_B) begin
            ctrl_d.scheme = chgport_pkg::SCH_DIV_B;
        end else if (auto_q == chgport_pkg::AUTO_V12) begin
            ctrl_d.scheme = chgport_pkg::SCH_V12;
        end else if (auto_q == chgport_pkg::AUTO_BC12) begin
            ctrl_d.scheme = chgport_pkg::SCH_SHORT;
        end else begin
            ctrl_d.scheme = chgport_pkg::SCH_DIV_A;
        end
        lp_d    = is_pw ? (pw_q != chgport_pkg::PW_IDLE) : ld_q;
        // Overtemperature skips the filter so a hot die is seen at once
        fault_d = therm_q || sense_s.over_155 || dg_done;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q           <= 4'h0;
            ld_q             <= 1'b0;
            disch_q          <= 1'b0;
            disch_len_q      <= 32'h00000001;
            auto_q           <= chgport_pkg::AUTO_DIV_A;
            pw_q             <= chgport_pkg::PW_FULL;
            therm_q          <= 1'b0;
            uv_q             <= 1'b1;
            ctrl             <= '0;
            load_present_out <= 1'b0;
            load_present_oe  <= 1'b0;
            fault_out        <= 1'b0;
            fault_oe         <= 1'b0;
        end else begin
            prev_q           <= mode;
            ld_q             <= ld_d;
            disch_q          <= disch_d;
            disch_len_q      <= disch_len_d;
            auto_q           <= auto_d;
            pw_q             <= pw_d;
            therm_q          <= therm_d;
            uv_q             <= uv_d;
            ctrl             <= ctrl_d;
            load_present_out <= 1'b0;
            load_present_oe  <= lp_d;
            fault_out        <= 1'b0;
            fault_oe         <= fault_d;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_attach;
        is_auto && auto_q == chgport_pkg::AUTO_DIV_A && sense_s.device_attach && !disch_q;
    endsequence
    sequence s_discharging;
        auto_q == chgport_pkg::AUTO_DISCH && disch_q;
    endsequence

    a_ld_rise_cause: assert property ($rose(ld_q) |-> $past(at_done || (is_cdp && sense_s.primary_detect)))
        else $error("load-present rose without cause");
    a_primary_detect: assert property (is_cdp && sense_s.primary_detect |=> ld_q ##1 load_present_oe)
        else $error("primary detection ignored");
    a_ld_fall_cause: assert property ($fell(ld_q) |-> $past(rt_done || !ld_active))
        else $error("load-present fell early");
    a_high_limit_cdp: assert property (is_cdp |=> ctrl.high_limit_sel)
        else $error("downstream port not on high limit");
    a_swap_no_disch: assert property (
        mode == chgport_pkg::MODE_CDP && $past(mode) == chgport_pkg::MODE_STANDARD_PORT_VARIANT_B && !disch_q |=> !disch_q)
        else $error("discharge on variant B swap");
    a_fault_hot: assert property (sense_s.over_155 |=> fault_oe)
        else $error("overtemperature fault late");
    a_fault_filter: assert property ($rose(fault_oe) |-> $past(dg_done || therm_q || sense_s.over_155))
        else $error("unfiltered current-limit fault");
    a_therm_off: assert property (therm_q |=> !ctrl.switch_on)
        else $error("switch on while hot");
    a_uv_lock: assert property (uv_q |=> !ctrl.switch_on)
        else $error("switch on under undervoltage");
    a_attach_seq: assert property (s_attach |=> s_discharging ##1 ctrl.discharge)
        else $error("attach did not discharge");
    a_bc12_hold: assert property (
        is_auto && auto_q == chgport_pkg::AUTO_BC12 && !sense_s.line_released |=> auto_q == chgport_pkg::AUTO_BC12)
        else $error("dedicated mode left early");
    // A mode change right after idle entry legally drops the reduced limit
    a_pw_idle: assert property (
        is_pw && pw_q == chgport_pkg::PW_FULL && pw_done |=> pw_q == chgport_pkg::PW_IDLE
        ##1 !load_present_oe && (ctrl.pw_limit || !$past(is_pw)))
        else $error("supply wake idle not entered");
endmodule // charge_port_ctrl

// ---- verif/load_model.sv ----
/* Attached-load model: turns a load current into comparator levels.
   Assumes the bench sets load_ma and drives the other sense levels. */
`timescale 1ns/1ps
module load_model #(
    parameter int LOW_MA = 900
) (
    // Load and bench levels
    input  wire logic [15:0]         load_ma,
    input  wire chgport_pkg::sense_t other,
    // Comparator levels
    output chgport_pkg::sense_t      sense
);
    // Pure levels, so timing stays with the design's syncs
    always_comb begin
        sense = other;
        sense.load_above_assert  = load_ma > LOW_MA + 60;
        sense.load_below_release = load_ma < LOW_MA + 10;
        sense.chg_above_750      = load_ma > 750;
        sense.chg_below_45       = load_ma < 45;
    end
endmodule // load_model

// ---- verif/charge_port_ctrl_bench.sv ----
/* Bench for charge_port_ctrl with shortened timers.
   Assumes the package and load model are compiled first. */
`timescale 1ns/1ps
module charge_port_ctrl_bench;
    localparam int LA = 20, LR = 30, DG = 8, MD = 10;
    logic                    sys_clk, arst_n, lp_out, lp_oe, f_out, f_oe;
    logic [15:0]             load_ma;
    chgport_pkg::mode_pins_t mode_pins;
    chgport_pkg::sense_t     ext, sense;
    chgport_pkg::port_ctrl_t ctrl;
    int                      n_mismatch, compares;
    int                      cyc = 0;

    load_model i_load_model (.load_ma(load_ma), .other(ext), .sense(sense));
    charge_port_ctrl #(.LD_ASSERT_CYC(LA), .LD_RELEASE_CYC(LR), .PW_IDLE_CYC(16),
        .PW_DISCH_CYC(12), .DEGLITCH_CYC(DG), .ATTACH_DISCH_CYC(10),
        .MODE_DISCH_CYC(MD), .V12_HOLD_CYC(6), .DIVB_TEST_CYC(10)
    ) i_charge_port_ctrl (.sys_clk(sys_clk), .arst_n(arst_n), .mode_pins(mode_pins),
        .sense(sense), .ctrl(ctrl), .load_present_out(lp_out),
        .load_present_oe(lp_oe), .fault_out(f_out), .fault_oe(f_oe));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask

    function automatic logic sig(input int k);
        case (k)
            0: return lp_oe;
            1: return f_oe;
            2: return ctrl.switch_on;
            3: return ctrl.discharge;
            default: return ctrl.pw_limit;
        endcase
    endfunction

    // Bounded wait; the count also proves the dwell length
    task automatic waitv(input string what, input int k, input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (sig(k) !== v && n <= hi) begin
            @(negedge sys_clk);
            n++;
        end
        chk(what, 8'h01, {7'h0, n >= lo && n <= hi});
    endtask

    task automatic go(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Mode change discharges first, so let it finish
    task automatic setm(input logic [3:0] m);
        mode_pins = m;
        go(MD + 6);
    endtask

    task automatic t_load;
        setm(4'hF);
        load_ma = 16'h3E8;
        go(LA - 5);
        load_ma = 16'h3A2;
        go(2);
        load_ma = 16'h3E8;
        go(LA - 5);
        chk("lp oe early", 8'h00, lp_oe);
        waitv("lp rise", 0, 1'h1, 1, 10);
        chk("lp pin level", 8'h00, lp_out);
        load_ma = 16'h389;
        waitv("lp fall", 0, 1'h0, LR, LR + 6);
        ext.primary_detect = 1'h1;
        waitv("lp detect", 0, 1'h1, 1, 5);
        ext.primary_detect = 1'h0;
        setm(4'hE);
        chk("limit sel b", 8'h00, ctrl.high_limit_sel);
        mode_pins = 4'hF;
        go(5);
        chk("no discharge", 8'h00, ctrl.discharge);
        chk("limit sel cdp", 8'h01, ctrl.high_limit_sel);
        $display("test load done");
    endtask

    task automatic t_fault;
        ext.over_155 = 1'h1;
        waitv("fault hot", 1, 1'h1, 1, 4);
        chk("fault pin level", 8'h00, f_out);
        go(1);
        chk("switch hot", 8'h00, ctrl.switch_on);
        ext.over_155 = 1'h0;
        ext.cooled = 1'h1;
        waitv("switch cool", 2, 1'h1, 1, 5);
        chk("fault clear", 8'h00, f_oe);
        ext.cooled = 1'h0;
        ext.in_current_limit = 1'h1;
        waitv("fault limit", 1, 1'h1, DG, DG + 5);
        ext.over_135 = 1'h1;
        waitv("switch 135", 2, 1'h0, 1, 5);
        ext.over_135 = 1'h0;
        ext.in_current_limit = 1'h0;
        // Thermal off holds the fault until the die has cooled
        ext.cooled = 1'h1;
        waitv("fault gone", 1, 1'h0, 1, 5);
        chk("switch back", 8'h01, ctrl.switch_on);
        ext.vin_above_on = 1'h0;
        ext.vin_below_off = 1'h1;
        waitv("switch uv", 2, 1'h0, 1, 5);
        ext.vin_below_off = 1'h0;
        go(6);
        chk("uv hyst", 8'h00, ctrl.switch_on);
        ext.vin_above_on = 1'h1;
        waitv("switch vin", 2, 1'h1, 1, 5);
        $display("test fault done");
    endtask

    task automatic t_auto;
        load_ma = 16'h1F4;
        setm(4'h2);
        chk("start div a", 8'h00, ctrl.scheme);
        ext.device_attach = 1'h1;
        waitv("attach disch", 3, 1'h1, 1, 5);
        ext.device_attach = 1'h0;
        waitv("disch end", 3, 1'h0, 10, 14);
        go(1);
        chk("v12", 8'h02, ctrl.scheme);
        go(18);
        chk("bc12 hold", 8'h03, ctrl.scheme);
        ext.line_released = 1'h1;
        go(5);
        chk("released", 8'h00, ctrl.scheme);
        ext.line_released = 1'h0;
        load_ma = 16'h320;
        go(5);
        chk("div b try", 8'h01, ctrl.scheme);
        load_ma = 16'h1F4;
        go(12);
        chk("div b back", 8'h00, ctrl.scheme);
        load_ma = 16'h320;
        go(18);
        chk("div b stay", 8'h01, ctrl.scheme);
        setm(4'h8);
        ext.device_attach = 1'h1;
        go(15);
        chk("forced short", 8'h03, ctrl.scheme);
        setm(4'hA);
        ext.device_attach = 1'h0;
        chk("forced div a", 8'h00, ctrl.scheme);
        $display("test auto done");
    endtask

    task automatic t_wake;
        load_ma = 16'h64;
        setm(4'h3);
        load_ma = 16'h0A;
        waitv("pw idle", 4, 1'h1, 16, 24);
        chk("pw lp off", 8'h00, lp_oe);
        ext.in_current_limit = 1'h1;
        waitv("pw disch", 3, 1'h1, 1, 5);
        chk("pw lp on", 8'h01, lp_oe);
        ext.in_current_limit = 1'h0;
        load_ma = 16'h64;
        waitv("pw resume", 3, 1'h0, 12, 18);
        chk("pw limit off", 8'h00, ctrl.pw_limit);
        chk("pw high limit", 8'h01, ctrl.high_limit_sel);
        $display("test wake done");
    endtask

    initial begin
        sys_clk = 1'h0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            give_verdict;
        end
    end

    initial begin
        arst_n = 1'h0;
        mode_pins = 4'h0;
        ext = '0;
        ext.vin_above_on = 1'h1;
        load_ma = 16'h64;
        n_mismatch = 0;
        compares = 0;
        go(20);
        arst_n = 1'h1;
        t_load;
        t_fault;
        t_auto;
        t_wake;
        give_verdict;
    end
endmodule // charge_port_ctrl_bench
